// ### dgsr_host.sv
// Host model; each call holds one command for exactly one edge, so calls run back to back.
module dgsr_host (output logic WR_STB, RD_STB, output logic [4:0] ADDR, output logic [15:0] WDATA, input wire logic CLK);
	timeunit 1ns;
	timeprecision 1ps;
	initial {WR_STB, RD_STB, ADDR, WDATA} = '0;
	task cmd(logic w, r, logic [4:0] a, logic [15:0] d);
		{WR_STB, RD_STB, ADDR, WDATA} = {w, r, a, d};
		@(posedge CLK) #1;
	endtask
endmodule // dgsr_host

// ### dgsr_pkg.sv
// Package for the gain and status register: address, field positions, reset values.
// Assumes a single clock domain shared with the serial command decoder.
package dgsr_pkg;

	// ============================================================
	// Register map
	localparam logic [4:0] DGSR_ADDR = 5'h0A;
	localparam int DGSR_WIDTH = 16;

	// ============================================================
	// Field positions
	localparam int DGSR_CH1_GAIN_BIT = 9;
	localparam int DGSR_CH0_GAIN_BIT = 8;
	localparam int DGSR_RST_FLAG_BIT = 7;

	// ============================================================
	// Values after reset
	localparam logic DGSR_GAIN_RST = 1'b0;
	localparam logic DGSR_FLAG_RST = 1'b1;
	localparam logic [15:0] DGSR_RDATA_RST = 16'h0000;

	// Command strobes from the serial decoder, all on the device clock.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [15:0] wdata;
	} dgsr_cmd_s;

	// Complete state of the register.
	typedef struct packed {
		logic ch1_double_gain;
		logic ch0_double_gain;
		logic rst_flag;
		logic [15:0] rdata;
	} dgsr_state_s;

endpackage

// ### dgsr_reg.sv
// Gain control and system status register of a one- or two-channel DAC.
// Assumes the serial command decoder runs on CLK and gives one-cycle read and write strobes.
module dgsr_reg import dgsr_pkg::*; #(
	parameter int NUM_CHANNELS = 2
) (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic WR_STB,
	input wire logic RD_STB,
	input wire logic [4:0] ADDR,
	input wire logic [15:0] WDATA,
	output logic [15:0] RDATA,
	output logic CH0_DOUBLE_GAIN,
	output logic CH1_DOUBLE_GAIN
);

	// ============================================================
	// Command decode
	dgsr_cmd_s cmd;
	logic hit;

	always_comb begin
		cmd.wr = WR_STB;
		cmd.rd = RD_STB;
		cmd.addr = ADDR;
		cmd.wdata = WDATA;
	end

	assign hit = (cmd.addr == DGSR_ADDR);

	// ============================================================
	// Strobe qualification
	logic wr_hit;
	logic rd_hit;
	logic rd_miss;

	assign wr_hit = cmd.wr && hit;
	assign rd_hit = cmd.rd && hit;
	assign rd_miss = cmd.rd && !hit;

	// ============================================================
	// Command kind
	// Codes are one-hot so that a stuck or doubled code falls into the default branch.
	typedef enum logic [4:0] {
		KIND_IDLE = 5'b00001,
		KIND_WRITE = 5'b00010,
		KIND_READ = 5'b00100,
		KIND_BOTH = 5'b01000,
		KIND_MISS = 5'b10000
	} dgsr_kind_e;

	dgsr_kind_e kind;

	// A write to another register together with a read of this one cannot happen,
	// since both strobes share one address.
	always_comb begin
		case ({wr_hit, rd_hit, rd_miss})
			3'b110: begin
				kind = KIND_BOTH;
			end
			3'b100: begin
				kind = KIND_WRITE;
			end
			3'b010: begin
				kind = KIND_READ;
			end
			3'b001: begin
				kind = KIND_MISS;
			end
			default: begin
				kind = KIND_IDLE;
			end
		endcase
	end

	// ============================================================
	// Implemented bit map
	// Pad bits are cut out of both the write path and the read path.
	logic [DGSR_WIDTH-1:0] impl_mask;
	logic [DGSR_WIDTH-1:0] gain_mask;

	for (genvar i = 0; i < DGSR_WIDTH; i++) begin : g_map
		if (i == DGSR_CH0_GAIN_BIT) begin : g_ch0
			assign impl_mask[i] = 1'b1;
			assign gain_mask[i] = 1'b1;
		end else if ((i == DGSR_CH1_GAIN_BIT) && (NUM_CHANNELS > 1)) begin : g_ch1
			assign impl_mask[i] = 1'b1;
			assign gain_mask[i] = 1'b1;
		end else if (i == DGSR_RST_FLAG_BIT) begin : g_flag
			assign impl_mask[i] = 1'b1;
			// The flag is readable but never writable.
			assign gain_mask[i] = 1'b0;
		end else begin : g_pad
			assign impl_mask[i] = 1'b0;
			assign gain_mask[i] = 1'b0;
		end
	end

	// ============================================================
	// State
	dgsr_state_s state_r;
	dgsr_state_s state_nxt;

	// ============================================================
	// Register word as it stands now
	logic [DGSR_WIDTH-1:0] live_word;
	logic [DGSR_WIDTH-1:0] rd_word;
	logic [DGSR_WIDTH-1:0] wr_word;

	always_comb begin
		live_word = '0;
		live_word[DGSR_CH1_GAIN_BIT] = state_r.ch1_double_gain;
		live_word[DGSR_CH0_GAIN_BIT] = state_r.ch0_double_gain;
		live_word[DGSR_RST_FLAG_BIT] = state_r.rst_flag;
	end

	always_comb begin
		rd_word = '0;
		for (int i = 0; i < DGSR_WIDTH; i++) begin
			if (impl_mask[i]) begin
				rd_word[i] = live_word[i];
			end else begin
				rd_word[i] = 1'b0;
			end
		end
	end

	always_comb begin
		wr_word = '0;
		for (int i = 0; i < DGSR_WIDTH; i++) begin
			if (gain_mask[i]) begin
				wr_word[i] = cmd.wdata[i];
			end else begin
				wr_word[i] = 1'b0;
			end
		end
	end

	// ============================================================
	// Next state
	// SRST stands for the power-on or brown-out event of the device.
	always_comb begin
		state_nxt = state_r;

		case (kind)
			KIND_WRITE: begin
				state_nxt.ch0_double_gain = wr_word[DGSR_CH0_GAIN_BIT];
				state_nxt.ch1_double_gain = wr_word[DGSR_CH1_GAIN_BIT];
			end

			KIND_READ: begin
				// The word is captured before the flag clears, so the host sees the old flag.
				state_nxt.rdata = rd_word;
				state_nxt.rst_flag = 1'b0;
			end

			KIND_BOTH: begin
				// The read shows the gains from before the write takes effect.
				state_nxt.rdata = rd_word;
				state_nxt.rst_flag = 1'b0;
				state_nxt.ch0_double_gain = wr_word[DGSR_CH0_GAIN_BIT];
				state_nxt.ch1_double_gain = wr_word[DGSR_CH1_GAIN_BIT];
			end

			KIND_MISS: begin
				state_nxt.rdata = DGSR_RDATA_RST;
			end

			KIND_IDLE: begin
				state_nxt = state_r;
			end

			default: begin
				state_nxt = state_r;
			end
		endcase
	end

	// ============================================================
	// Registers
	// A reset in the same cycle as a read wins: the flag is set again and that read returns nothing.
	always_ff @(posedge CLK) begin
		if (SRST) begin
			state_r.ch0_double_gain <= DGSR_GAIN_RST;
			state_r.ch1_double_gain <= DGSR_GAIN_RST;
			state_r.rst_flag <= DGSR_FLAG_RST;
			state_r.rdata <= DGSR_RDATA_RST;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ============================================================
	// Outputs
	assign RDATA = state_r.rdata;
	assign CH0_DOUBLE_GAIN = state_r.ch0_double_gain;
	// On the single-channel variant this output is tied to 0, whatever the register holds.
	assign CH1_DOUBLE_GAIN = (NUM_CHANNELS > 1) ? state_r.ch1_double_gain : 1'b0;

endmodule // dgsr_reg

// ### dgsr_reg_asserts.sv
// Checker bound onto dgsr_reg; it sees only the register ports on one clock.
module dgsr_reg_asserts import dgsr_pkg::*; #(parameter int NUM_CHANNELS = 2) (input wire logic CLK, SRST, WR_STB, RD_STB,
input wire logic [4:0] ADDR, input wire logic [15:0] WDATA, RDATA, input wire logic CH0_DOUBLE_GAIN, CH1_DOUBLE_GAIN);
	wire r = RD_STB && ADDR == DGSR_ADDR;
	wire w = WR_STB && ADDR == DGSR_ADDR;
	wire [1:0] g = {CH1_DOUBLE_GAIN, CH0_DOUBLE_GAIN};
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	sequence rr_s; r ##1 r; endsequence
	a_pad_zero: assert property ({RDATA[15:10], RDATA[6:0]} == 13'h0) else $error("pad");
	a_flag_clear: assert property (rr_s |=> !RDATA[7]) else $error("flag");
	a_ch0_write: assert property (w |=> g[0] == $past(WDATA[8])) else $error("ch0");
	a_ch1_write: assert property (w |=> g[1] == (NUM_CHANNELS > 1 ? $past(WDATA[9]) : 1'b0)) else $error("ch1");
	a_flag_set: assert property ($past(SRST) && r |=> RDATA[7]) else $error("set");
	a_gain_hold: assert property (!SRST && !w |=> $stable(g)) else $error("hold");
	a_read_gain: assert property (r |=> RDATA[9:8] == $past(g)) else $error("rgain");
	a_bad_addr: assert property (RD_STB && !r |=> RDATA == 16'h0) else $error("addr");
	a_rdata_hold: assert property (!SRST && !RD_STB |=> $stable(RDATA)) else $error("rhold");
endmodule // dgsr_reg_asserts
bind dgsr_reg dgsr_reg_asserts #(.NUM_CHANNELS(NUM_CHANNELS)) a_u (.*);

// ### dgsr_reg_tb.sv
// Bench for dgsr_reg, driven through the host model.
module dgsr_reg_tb import dgsr_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK = 0, SRST = 1, WR_STB, RD_STB, CH0_DOUBLE_GAIN, CH1_DOUBLE_GAIN;
	logic [4:0] ADDR;
	logic [15:0] WDATA, RDATA, m = 16'h0300;
	logic [7:0] s = 8'h5C;
	int errors, checked;
	always #4 CLK = ~CLK;
	dgsr_reg dut_u (.*);
	dgsr_host h_u (.*);
	function logic [7:0] nx(logic [7:0] v); return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]}; endfunction
	task chk(logic [15:0] got, e); checked++; if (got !== e) begin errors++; $display("wrong value %0t %h %h", $time, got, e); end endtask
	task complete_run; if (errors == 0 && checked > 0) $display("== PASSED =="); else $display("== FAILED =="); $finish; endtask
	initial begin #9000; errors++; complete_run; end
	initial begin
		repeat (20) @(posedge CLK);
		#1 SRST = 0;
		h_u.cmd(0, 1, DGSR_ADDR, 16'h0); chk(RDATA, 16'h0080);
		h_u.cmd(0, 1, DGSR_ADDR, 16'h0); chk(RDATA, 16'h0000);
		h_u.cmd(1, 0, DGSR_ADDR, 16'hFFFF); h_u.cmd(0, 1, DGSR_ADDR, 16'h0); chk(RDATA, m);
		repeat (30) begin
			s = nx(s);
			h_u.cmd(1, 1, s[0] ? DGSR_ADDR : s[5:1], {6'h00, s[7:6], 8'hFF});
			chk(RDATA, ADDR == DGSR_ADDR ? m : 16'h0000);
			if (ADDR == DGSR_ADDR) m = {6'h00, s[7:6], 8'h00};
			chk({6'h00, CH1_DOUBLE_GAIN, CH0_DOUBLE_GAIN, 8'h00}, m);
		end
		h_u.cmd(0, 0, ~ADDR, ~WDATA);
		SRST = 1;
		@(posedge CLK) #1 SRST = 0;
		h_u.cmd(0, 1, DGSR_ADDR, 16'h0); chk(RDATA, 16'h0080);
		chk({6'h00, CH1_DOUBLE_GAIN, CH0_DOUBLE_GAIN, 8'h00}, 16'h0000);
		complete_run;
	end
endmodule // dgsr_reg_tb
